/* File: include/acu_params.svh */
// Register offsets, field positions and reset values of the compare unit.
`ifndef ACU_PARAMS_SVH
`define ACU_PARAMS_SVH

`define ACU_AW            8
`define ACU_DW            32
`define ACU_OFS_CTRL      8'h00
`define ACU_OFS_STATUS    8'h04
`define ACU_OFS_MASK      8'h08

`define ACU_CTRL_EN       0
`define ACU_CTRL_BGAP     1
`define ACU_CTRL_IE       2
`define ACU_CTRL_PE       3
`define ACU_CTRL_MODE_LO  4
`define ACU_CTRL_MODE_HI  5
`define ACU_CTRL_W        6
`define ACU_CTRL_RST      6'h00

`define ACU_ST_FLAG       0
`define ACU_ST_RES        1
`define ACU_MASK_RST      1'h0
`define ACU_RDATA_ZERO    32'h0000_0000

`endif

/* File: include/acu_pkg.sv */
// Types shared by the compare unit modules.
package acu_pkg;

  typedef enum logic [1:0] {
    ACU_EDGE_FALL,
    ACU_EDGE_RISE,
    ACU_EDGE_BOTH_ALT,
    ACU_EDGE_BOTH
  } acu_edge_t;

endpackage

/* File: hdl/acu_sync.sv */
// Two-stage synchroniser for the asynchronous comparator output.
`timescale 1ns/1ns
module acu_sync (
  input  wire logic pclk,     // Bus clock.
  input  wire logic presetn,  // Asynchronous reset, active low.
  input  wire logic clk_en,   // Clock enable, freezes state when low.
  input  wire logic async_in, // Level from outside the clock domain.
  output logic      sync_out  // Level safe to use on pclk.
);

  logic meta_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_reg <= 1'b0;
      sync_out <= 1'b0;
    end else if (clk_en) begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

/* File: hdl/acu_edge.sv */
// Edge detector with selectable rising, falling or either edge.
`timescale 1ns/1ns
module acu_edge
  import acu_pkg::*;
(
  input  wire logic       pclk,    // Bus clock.
  input  wire logic       presetn, // Asynchronous reset, active low.
  input  wire logic       clk_en,  // Clock enable.
  input  wire logic       level,   // Synchronised comparator result.
  input  wire logic       enable,  // Comparator enabled.
  input  wire acu_edge_t  mode,    // Edge selection.
  output logic            evt      // One-cycle qualifying edge pulse.
);

  logic prev_reg;
  logic rise;
  logic fall;

  // The previous level tracks even while disabled, so enabling the
  // comparator never reports a stale edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_reg <= 1'b0;
    end else if (clk_en) begin
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;

  always_comb begin
    case (mode)
      ACU_EDGE_FALL: evt = enable & fall;
      ACU_EDGE_RISE: evt = enable & rise;
      default:       evt = enable & (rise | fall);
    endcase
  end

endmodule

/* File: hdl/acu_top.sv */
// Analog compare unit control: registers, edge flag, pin and wake-up.
//
// Overview of operation
// R01: Software picks rising, falling or either edge.
// R02: Option selects internal bandgap as one input.
// R03: Pin enable drives comparator result onto pin.
// R04: Runs in wait; enabled interrupt wakes processor.
// R05: Software disables comparator in wait to save current.
// R06: Light stop keeps comparing and edge detection.
// R07: Light stop keeps driving result pin.
// R08: Light stop event sets flag, wakes if enabled.
// R09: Stop exit by reset restores reset state.
// R10: Deep stop powers down, releases the pin and clears control, mask and flag.
// R11: Debug halt leaves comparator fully operating.
// R12: Synchronise result; flag sticky until software clears.
//
// Added by the designer: the register offsets and the APB register port.
`timescale 1ns/1ns
`include "acu_params.svh"
module acu_top
  import acu_pkg::*;
(
  input  wire logic                pclk,             // Bus clock.
  input  wire logic                presetn,          // Reset, active low.
  input  wire logic                clk_en,           // Clock enable.
  input  wire logic                psel,             // APB select.
  input  wire logic                penable,          // APB enable.
  input  wire logic                pwrite,           // APB direction.
  input  wire logic [`ACU_AW-1:0]  paddr,            // APB byte address.
  input  wire logic [`ACU_DW-1:0]  pwdata,           // APB write data.
  output logic      [`ACU_DW-1:0]  prdata,           // APB read data.
  output logic                     pready,           // APB ready.
  output logic                     pslverr,          // APB error.
  input  wire logic                cmp_out_async,    // Raw comparator out.
  input  wire logic                wait_mode,        // Processor waiting.
  input  wire logic                light_stop_mode,  // Light stop active.
  input  wire logic                deep_stop_mode_a, // Deep stop, first.
  input  wire logic                deep_stop_mode_b, // Deep stop, second.
  input  wire logic                debug_halt,       // Background debug.
  output logic                     cmp_power_en,     // Powers comparator.
  output logic                     bandgap_sel,      // Bandgap reference.
  output logic                     compare_result_pin,    // Result pin.
  output logic                     compare_result_pin_oe, // Pin enable.
  output logic                     irq,              // Interrupt, level.
  output logic                     wakeup_req        // Wake processor.
);

  logic [`ACU_CTRL_W-1:0] ctrl_reg;
  logic                   flag_reg;
  logic                   mask_reg;
  logic [`ACU_DW-1:0]     prdata_reg;
  logic                   pslverr_reg;
  logic                   pin_reg;
  logic                   pin_oe_reg;
  logic                   irq_reg;
  logic                   wakeup_reg;
  logic                   irq_next;
  logic                   wakeup_next;

  logic                   res_sync;
  logic                   evt;
  logic                   deep_stop;
  logic                   setup;
  logic                   wr_acc;
  logic                   wr_ctrl;
  logic                   wr_status;
  logic                   wr_mask;
  logic                   clr_flag;
  logic                   mapped;

  logic                   ctl_en;
  logic                   ctl_bgap;
  logic                   ctl_ie;
  logic                   ctl_pe;
  acu_edge_t              ctl_mode;

  assign ctl_en   = ctrl_reg[`ACU_CTRL_EN];
  assign ctl_bgap = ctrl_reg[`ACU_CTRL_BGAP];
  assign ctl_ie   = ctrl_reg[`ACU_CTRL_IE];
  assign ctl_pe   = ctrl_reg[`ACU_CTRL_PE];
  assign ctl_mode = acu_edge_t'(ctrl_reg[`ACU_CTRL_MODE_HI:`ACU_CTRL_MODE_LO]);

  assign deep_stop = deep_stop_mode_a | deep_stop_mode_b;

  // Comparator result and edge detection.

  acu_sync u_acu_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .clk_en   (clk_en),
    .async_in (cmp_out_async),
    .sync_out (res_sync)                                  // [R12]
  );

  // No mode input reaches the detector: wait, light stop and debug halt
  // all leave it running exactly as in normal operation.
  acu_edge u_acu_edge (
    .pclk    (pclk),
    .presetn (presetn),
    .clk_en  (clk_en),
    .level   (res_sync),
    .enable  (ctl_en),
    .mode    (ctl_mode),                                  // [R01]
    .evt     (evt)                                        // [R06] [R11]
  );

  // APB slave: zero wait states while the clock enable is high.

  assign setup  = psel & ~penable;
  assign wr_acc = psel & penable & pready & pwrite;
  assign mapped = (paddr == `ACU_OFS_CTRL) ||
                  (paddr == `ACU_OFS_STATUS) ||
                  (paddr == `ACU_OFS_MASK);

  always_comb begin
    wr_ctrl   = 1'b0;
    wr_status = 1'b0;
    wr_mask   = 1'b0;
    if (wr_acc && paddr == `ACU_OFS_CTRL) begin
      wr_ctrl = 1'b1;
    end else if (wr_acc && paddr == `ACU_OFS_STATUS) begin
      wr_status = 1'b1;
    end else if (wr_acc && paddr == `ACU_OFS_MASK) begin
      wr_mask = 1'b1;
    end
  end

  assign clr_flag = wr_status & pwdata[`ACU_ST_FLAG];
  assign pready   = clk_en;
  assign prdata   = prdata_reg;
  assign pslverr  = pslverr_reg;

  // Read data and error are captured in the setup cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg  <= `ACU_RDATA_ZERO;
      pslverr_reg <= 1'b0;
    end else if (clk_en && setup) begin
      prdata_reg  <= `ACU_RDATA_ZERO;
      pslverr_reg <= ~mapped;
      if (paddr == `ACU_OFS_CTRL) begin
        prdata_reg[`ACU_CTRL_W-1:0] <= ctrl_reg;
      end else if (paddr == `ACU_OFS_STATUS) begin
        prdata_reg[`ACU_ST_FLAG] <= flag_reg;
        prdata_reg[`ACU_ST_RES]  <= res_sync;
      end else if (paddr == `ACU_OFS_MASK) begin
        prdata_reg[`ACU_ST_FLAG] <= mask_reg;
      end
    end
  end

  // Control register; deep stop returns it to reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= `ACU_CTRL_RST;                          // [R09]
    end else if (clk_en) begin
      if (deep_stop) begin
        ctrl_reg <= `ACU_CTRL_RST;                        // [R10]
      end else if (wr_ctrl) begin
        ctrl_reg <= pwdata[`ACU_CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_reg <= `ACU_MASK_RST;                          // [R09]
    end else if (clk_en) begin
      if (deep_stop) begin
        mask_reg <= `ACU_MASK_RST;                        // [R10]
      end else if (wr_mask) begin
        mask_reg <= pwdata[`ACU_ST_FLAG];
      end
    end
  end

  // Event flag: a new event wins over a write-one-to-clear.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flag_reg <= 1'b0;                                   // [R09]
    end else if (clk_en) begin
      if (deep_stop) begin
        flag_reg <= 1'b0;                                 // [R10]
      end else if (evt) begin
        flag_reg <= 1'b1;                                 // [R08] [R11]
      end else if (clr_flag) begin
        flag_reg <= 1'b0;                                 // [R12]
      end
    end
  end

  // Analog side and result pin.

  assign cmp_power_en = ctl_en & ~deep_stop;              // [R10]
  assign bandgap_sel  = ctl_bgap;                         // [R02]
  assign compare_result_pin    = pin_reg;
  assign compare_result_pin_oe = pin_oe_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_reg    <= 1'b0;
      pin_oe_reg <= 1'b0;
    end else if (clk_en) begin
      pin_oe_reg <= ctl_en & ctl_pe & ~deep_stop;         // [R03] [R07]
      pin_reg    <= ctl_en & ctl_pe & ~deep_stop & res_sync;
    end
  end

  // Interrupt and wake-up requests.

  assign irq_next    = flag_reg & mask_reg & ctl_ie;      // [R01]
  assign wakeup_next = irq_next & (wait_mode | light_stop_mode);
  assign irq         = irq_reg;
  assign wakeup_req  = wakeup_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_reg    <= 1'b0;
      wakeup_reg <= 1'b0;
    end else if (clk_en) begin
      irq_reg    <= irq_next;
      wakeup_reg <= wakeup_next;                          // [R04] [R08]
    end
  end

  // Checks.

  default clocking acu_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  edge_rise_a: assert property ( // [R01]
    (clk_en && ctl_en && !deep_stop && ctl_mode == ACU_EDGE_RISE &&
     res_sync && !$past(res_sync) && $past(clk_en)) |=> flag_reg
  ) else $error("rising edge did not set the event flag");

  edge_only_a: assert property ( // [R01]
    (clk_en && ctl_mode == ACU_EDGE_FALL && !$past(res_sync) &&
     res_sync && !flag_reg) |=> !flag_reg
  ) else $error("flag set on an edge that was not selected");

  bandgap_wr_a: assert property ( // [R02]
    (wr_ctrl && clk_en && !deep_stop && pwdata[`ACU_CTRL_BGAP])
      |=> bandgap_sel
  ) else $error("bandgap select did not follow the control write");

  pin_drive_a: assert property ( // [R03]
    (clk_en && ctl_en && ctl_pe && !deep_stop) |=>
      (compare_result_pin_oe && compare_result_pin == $past(res_sync))
  ) else $error("result pin does not show the comparator result");

  pin_stop_a: assert property ( // [R07]
    (clk_en && light_stop_mode && ctl_en && ctl_pe && !deep_stop)
      [*2] |-> compare_result_pin_oe
  ) else $error("result pin released during light stop");

  wait_wake_a: assert property ( // [R04]
    (clk_en && wait_mode && flag_reg && mask_reg && ctl_ie &&
     !deep_stop) |=> wakeup_req
  ) else $error("event did not wake the processor from wait");

  stop_flag_a: assert property ( // [R06]
    (clk_en && light_stop_mode && evt && !deep_stop) |=> flag_reg
  ) else $error("event lost during light stop");

  stop_wake_a: assert property ( // [R08]
    (clk_en && light_stop_mode && evt && ctl_ie && mask_reg &&
     !deep_stop) ##1 (clk_en && light_stop_mode && ctl_ie && mask_reg)
      |=> wakeup_req
  ) else $error("event did not wake the processor from light stop");

  deep_clear_a: assert property ( // [R10]
    (clk_en && deep_stop) |=>
      (ctrl_reg == `ACU_CTRL_RST && !flag_reg && !cmp_power_en)
  ) else $error("deep stop left comparator state set");

  debug_run_a: assert property ( // [R11]
    (clk_en && debug_halt && evt && !deep_stop) |=> flag_reg
  ) else $error("event lost during debug halt");

  flag_sticky_a: assert property ( // [R12]
    (flag_reg && !(clk_en && (clr_flag || deep_stop)))
      |=> flag_reg
  ) else $error("event flag cleared without software");

  set_wins_a: assert property ( // [R12]
    (clk_en && evt && clr_flag && !deep_stop) |=> flag_reg
  ) else $error("clear won over a simultaneous event");

  irq_level_a: assert property ( // [R01]
    (clk_en && !irq_next) |=> !irq
  ) else $error("interrupt high without an unmasked flag");

  irq_set_a: assert property ( // [R01]
    (clk_en && irq_next) |=> irq
  ) else $error("interrupt low with an unmasked flag set");

  mask_gate_a: assert property ( // [R01]
    (clk_en && !mask_reg) |=> !irq
  ) else $error("masked event raised the interrupt");

  fall_edge_a: assert property ( // [R01]
    (clk_en && ctl_en && !deep_stop && ctl_mode == ACU_EDGE_FALL &&
     !res_sync && $past(res_sync) && $past(clk_en)) |=> flag_reg
  ) else $error("falling edge did not set the event flag");

  both_edge_a: assert property ( // [R01]
    (clk_en && ctl_en && !deep_stop && ctl_mode != ACU_EDGE_FALL &&
     ctl_mode != ACU_EDGE_RISE && res_sync != $past(res_sync) &&
     $past(clk_en)) |=> flag_reg
  ) else $error("edge in either-edge mode did not set the flag");

  bandgap_clr_a: assert property ( // [R02]
    (wr_ctrl && clk_en && !deep_stop && !pwdata[`ACU_CTRL_BGAP])
      |=> !bandgap_sel
  ) else $error("bandgap select stayed on after the control write");

  pin_off_a: assert property ( // [R03]
    (clk_en && !(ctl_en && ctl_pe)) |=>
      (!compare_result_pin_oe && !compare_result_pin)
  ) else $error("result pin driven while not enabled");

  wait_run_a: assert property ( // [R04]
    (clk_en && wait_mode && evt && !deep_stop) |=> flag_reg
  ) else $error("event lost during wait");

  wake_only_a: assert property ( // [R04]
    (clk_en && !wait_mode && !light_stop_mode) |=> !wakeup_req
  ) else $error("wake-up requested outside wait and light stop");

  deep_pin_a: assert property ( // [R10]
    (clk_en && deep_stop) |=>
      (!compare_result_pin_oe && !mask_reg && !bandgap_sel)
  ) else $error("deep stop left the pin or mask active");

  debug_pin_a: assert property ( // [R11]
    (clk_en && debug_halt && ctl_en && ctl_pe && !deep_stop)
      |=> compare_result_pin_oe
  ) else $error("result pin released during debug halt");

  sync_delay_a: assert property ( // [R12]
    ($past(clk_en) && $past(clk_en, 2) && $past(presetn) &&
     $past(presetn, 2)) |-> res_sync == $past(cmp_out_async, 2)
  ) else $error("comparator result not delayed by two stages");

  flag_clear_a: assert property ( // [R12]
    (clk_en && clr_flag && !evt) |=> !flag_reg
  ) else $error("write of one did not clear the event flag");

endmodule

/* File: tb/acu_cmp_model.sv */
// Behavioural analog comparator core feeding the compare unit.
`timescale 1ns/1ns
module acu_cmp_model #(
  parameter int BG_MV = 1200 // Internal reference level in millivolts.
) (
  input  wire logic pwr_en,  // Core powered.
  input  wire logic bg_sel,  // Internal reference replaces minus input.
  input  int        v_pos,   // Plus input in millivolts.
  input  int        v_neg,   // Minus input in millivolts.
  output logic      cmp_out  // Raw comparison result.
);
  // An unpowered core gives a steady low rather than a stale level.
  assign cmp_out = pwr_en && (v_pos > (bg_sel ? BG_MV : v_neg));
endmodule

/* File: tb/tb_acu_top.sv */
// Self-checking bench for the analog compare unit control block.
`timescale 1ns/1ns
`include "acu_params.svh"
module tb_acu_top;
  import acu_pkg::*;
  localparam int BG_MV = 1200;
  logic               pclk, presetn, clk_en, psel, penable, pwrite;
  logic [`ACU_AW-1:0] paddr;
  logic [`ACU_DW-1:0] pwdata, prdata, rd;
  logic               pready, pslverr, er, cmp_raw, bg_sel, irq;
  logic               wait_mode, light_stop_mode, deep_a, deep_b;
  logic               debug_halt, power_en, res_pin, res_oe, wakeup_req;
  int                 vp, vm, err_total, checks_done, m, k, bg;

  acu_top u_acu_top (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cmp_out_async(cmp_raw), .wait_mode(wait_mode),
    .light_stop_mode(light_stop_mode), .deep_stop_mode_a(deep_a),
    .deep_stop_mode_b(deep_b), .debug_halt(debug_halt),
    .cmp_power_en(power_en), .bandgap_sel(bg_sel),
    .compare_result_pin(res_pin), .compare_result_pin_oe(res_oe),
    .irq(irq), .wakeup_req(wakeup_req));

  acu_cmp_model #(.BG_MV(BG_MV)) u_acu_cmp_model (
    .pwr_en(power_en), .bg_sel(bg_sel), .v_pos(vp), .v_neg(vm),
    .cmp_out(cmp_raw));

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [`ACU_AW-1:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Six edges cover two sync stages, the flag and the irq register.
  task automatic setv(input int v);
    @(posedge pclk);
    vp <= v;
    repeat (6) @(posedge pclk);
  endtask

  task automatic chk_reset();
    for (int i = 0; i < 3; i++) begin
      apb(1'b0, `ACU_AW'(4 * i), '0);
      chk("reset value", rd, '0);
    end
    chk("irq idle", irq, 1'b0);
    chk("pin idle", {res_pin, res_oe}, 2'b00);
  endtask

  function automatic logic exp_ev(input int md, input logic rise);
    return (md >= 2) || (rise ? md == 1 : md == 0);
  endfunction

  task automatic wrap_up();
    $display("Checks %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    wrap_up();
  end

  initial begin
    {psel, penable, pwrite, wait_mode, light_stop_mode} = '0;
    {deep_a, deep_b, debug_halt} = '0;
    presetn = 1'b0;
    clk_en = 1'b1;
    paddr = '0;
    pwdata = '0;
    vp = 500;
    vm = 1000;
    err_total = 0;
    checks_done = 0;
    void'($urandom(32'h759CCDB5));
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    chk_reset();
    apb(1'b0, 8'h0C, '0);
    chk("unmapped", {er, rd}, {1'b1, 32'h0});
    for (m = 0; m < 4; m++) begin
      apb(1'b1, `ACU_OFS_CTRL, 32'h5 | (m << 4));
      apb(1'b1, `ACU_OFS_MASK, 32'h1);
      setv(500);
      apb(1'b1, `ACU_OFS_STATUS, 32'h1);
      setv(1500);
      chk("irq on rise", irq, exp_ev(m, 1'b1));
      setv(500);
      apb(1'b0, `ACU_OFS_STATUS, '0);
      chk("flag", rd[0], exp_ev(m, 1'b1) | exp_ev(m, 1'b0));
      apb(1'b1, `ACU_OFS_STATUS, 32'h1);
      apb(1'b0, `ACU_OFS_STATUS, '0);
      chk("flag cleared", rd, '0);
    end
    apb(1'b1, `ACU_OFS_MASK, '0);
    setv(1500);
    chk("masked irq", irq, 1'b0);
    apb(1'b1, `ACU_OFS_MASK, 32'h1);
    repeat (2) @(posedge pclk);
    chk("unmasked irq", irq, 1'b1);
    apb(1'b1, `ACU_OFS_STATUS, 32'h1);
    repeat (2) @(posedge pclk);
    chk("irq cleared", irq, 1'b0);
    // Falling edge reaches the flag in the same cycle as the clear.
    @(posedge pclk);
    vp <= 500;
    apb(1'b1, `ACU_OFS_STATUS, 32'h1);
    apb(1'b0, `ACU_OFS_STATUS, '0);
    chk("set wins", rd[0], 1'b1);
    for (k = 0; k < 3; k++) begin
      apb(1'b1, `ACU_OFS_CTRL, 32'h1D);
      setv(500);
      chk("pin low", {res_pin, res_oe}, 2'b01);
      apb(1'b1, `ACU_OFS_STATUS, 32'h1);
      wait_mode <= (k == 0);
      light_stop_mode <= (k == 1);
      debug_halt <= (k == 2);
      setv(1500);
      chk("wake", wakeup_req, k < 2);
      chk("pin high", {res_pin, res_oe}, 2'b11);
      apb(1'b0, `ACU_OFS_STATUS, '0);
      chk("flag in mode", rd[1:0], 2'b11);
      {wait_mode, light_stop_mode, debug_halt} <= 3'b000;
    end
    apb(1'b1, `ACU_OFS_CTRL, '0);
    wait_mode <= 1'b1;
    setv(500);
    chk("idle in wait", {power_en, wakeup_req, irq}, 3'b000);
    wait_mode <= 1'b0;
    for (k = 0; k < 16; k++) begin
      bg = (k < 2) ? k : $urandom_range(1);
      apb(1'b1, `ACU_OFS_CTRL, 32'h1 | (bg << 1));
      setv((k < 2) ? 1100 : $urandom_range(2000));
      chk("bandgap sel", bg_sel, bg);
      apb(1'b0, `ACU_OFS_STATUS, '0);
      chk("result", rd[1], vp > (bg ? BG_MV : vm));
    end
    for (k = 0; k < 2; k++) begin
      apb(1'b1, `ACU_OFS_CTRL, 32'h1D);
      apb(1'b1, `ACU_OFS_MASK, 32'h1);
      chk("power on", power_en, 1'b1);
      setv(500);
      setv(1500);
      deep_a <= (k == 0);
      deep_b <= (k == 1);
      repeat (3) @(posedge pclk);
      chk("deep power", power_en, 1'b0);
      {deep_a, deep_b} <= 2'b00;
      chk_reset();
    end
    apb(1'b1, `ACU_OFS_CTRL, 32'h1D);
    setv(500);
    setv(1500);
    clk_en <= 1'b0;
    setv(500);
    chk("pready frozen", pready, 1'b0);
    chk("pin frozen", {res_pin, res_oe}, 2'b11);
    clk_en <= 1'b1;
    setv(1500);
    light_stop_mode <= 1'b1;
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    light_stop_mode <= 1'b0;
    chk_reset();
    wrap_up();
  end
endmodule
